//--- common/flash_ctl_defines.vh
// constants for the flash program/erase mode controller
// assumes inclusion by bare name from design files
`ifndef FLASH_CTL_DEFINES_VH
`define FLASH_CTL_DEFINES_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_BLOCK 8'h04
`define REG_ADDR 8'h08
`define REG_DATA 8'h0C
`define REG_CMD 8'h10
`define REG_STATUS 8'h14
`define REG_RDATA 8'h18
`define REG_BAUD 8'h1C
// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CTRL_SWE 0
`define CTRL_PROTECT 1
`define CTRL_RESET 2'h0
// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define CMD_PROGRAM 2'h1
`define CMD_ERASE 2'h2
`define CMD_ERASE_ALL 2'h3
// ------------------------------------------------------------
// operating modes (latched from mode pins)
// ------------------------------------------------------------
`define MODE_USER 2'h0
`define MODE_USER_PROG 2'h1
`define MODE_BOOT 2'h2
`define MODE_PROGRAMMER 2'h3
// ------------------------------------------------------------
// array geometry
// ------------------------------------------------------------
`define PAGE_BYTES 8'h80
`define ERASED_BYTE 8'hFF
`define ARRAY_AW 16
`define NUM_BLOCKS 8
// ------------------------------------------------------------
// timing: bit-rate measurement limit in cycles
// ------------------------------------------------------------
`define BAUD_MAX 16'hFFFF
`endif

//--- design/flash_block_map.v
// erase-block address range lookup
// assumes a 16-bit byte address into a 64-kbyte array
`timescale 1ns/10ps
module flash_block_map (
    input wire [2:0] block_idx,
    output reg [15:0] block_base,
    output reg [15:0] block_last
);
    // ------------------------------------------------------------
    // uneven map: four 1k, one 28k, one 16k, two 8k
    // ------------------------------------------------------------
    always @* begin
        case (block_idx)
            3'h0: begin block_base = 16'h0000; block_last = 16'h03FF; end
            3'h1: begin block_base = 16'h0400; block_last = 16'h07FF; end
            3'h2: begin block_base = 16'h0800; block_last = 16'h0BFF; end
            3'h3: begin block_base = 16'h0C00; block_last = 16'h0FFF; end
            3'h4: begin block_base = 16'h1000; block_last = 16'h7FFF; end
            3'h5: begin block_base = 16'h8000; block_last = 16'hBFFF; end
            3'h6: begin block_base = 16'hC000; block_last = 16'hDFFF; end
            default: begin block_base = 16'hE000; block_last = 16'hFFFF; end
        endcase
    end
endmodule // flash_block_map

//--- design/serial_rate_meter.v
// measures host serial bit time from first start bit
// assumes rx line idles high and is synchronous to aclk
`timescale 1ns/10ps
`include "flash_ctl_defines.vh"
module serial_rate_meter (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    input wire enable,
    input wire rx_in,
    output reg [15:0] bit_cycles_ff,
    output reg locked_ff
);
    reg rx_d_ff;
    reg busy_ff;
    reg [15:0] cnt_ff;
    // ------------------------------------------------------------
    // time the low start bit once, then lock the rate
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_d_ff <= 1'b1;
            busy_ff <= 1'b0;
            cnt_ff <= 16'h0000;
            bit_cycles_ff <= 16'h0000;
            locked_ff <= 1'b0;
        end else if (clk_en) begin
            rx_d_ff <= rx_in;
            if (enable && !locked_ff) begin
                if (!busy_ff && rx_d_ff && !rx_in) begin
                    busy_ff <= 1'b1;
                    cnt_ff <= 16'h0001;
                end else if (busy_ff && rx_in) begin
                    busy_ff <= 1'b0;
                    bit_cycles_ff <= cnt_ff;
                    locked_ff <= 1'b1;
                end else if (busy_ff && cnt_ff != `BAUD_MAX) begin
                    cnt_ff <= cnt_ff + 16'h0001;
                end
            end
        end
    end
endmodule // serial_rate_meter

//--- design/flash_mode_ctl.v
// flash array with mode latch, protection and page/block sequencer
// assumes AXI4-Lite master on aclk; mode pins steady during reset
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "flash_ctl_defines.vh"
// Function
// - programming writes one whole 128-byte page per operation
// - each block erase clears only the one selected block
// - array split into 1k x4, 28k, 16k, 8k x2 blocks
// - mode pins 1:0, sampled on the first enabled edge after reset, pick the mode
// - plain user mode reads only; program and erase refused
// - boot mode erases the whole array; no block erase
// - user program mode erases or programs any single block
// - boot mode measures host bit rate for the serial port
// - programmer mode lets an external programmer erase and program
// - software protect bit blocks all program and erase
// - erased bytes read as all ones
// - with write enable clear other control and block bits stay unset
// - protect pin blocks program/erase; status mirrors the pin
module flash_mode_ctl (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    input wire hw_write_protect_input,
    input wire mode_select_pin_2,
    input wire mode_select_pin_1,
    input wire mode_select_pin_0,
    input wire serial_rx,
    output wire [15:0] bit_rate_cycles,
    output wire [1:0] op_mode,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);
    localparam ST_IDLE = 2'h0;
    localparam ST_PROG = 2'h1;
    localparam ST_ERASE = 2'h2;

    reg [7:0] mem [0:65535];
    reg [7:0] page_buf [0:127];
    reg [1:0] mode_ff;
    reg mode_taken_ff;
    reg [1:0] ctrl_ff;
    reg [7:0] block_sel_ff;
    reg [15:0] addr_ff;
    reg [1:0] state_ff;
    reg [15:0] ptr_ff;
    reg [15:0] last_ff;
    reg [6:0] pg_idx_ff;
    reg refused_ff;
    reg bad_page_ff;
    reg [7:0] rbyte_ff;
    reg aw_ff;
    reg w_ff;
    reg [7:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0] rresp_ff;
    reg [2:0] blk_idx;
    reg [31:0] rd_mux;
    reg rd_ok;
    wire [15:0] blk_base;
    wire [15:0] blk_last;
    wire [15:0] rate;
    wire rate_locked;
    wire wr_go;
    wire wr_ok;
    wire busy;
    wire may_alter;
    wire [15:0] page_base;
    wire [1:0] cmd;
    integer i;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    flash_block_map u_map (
        .block_idx(blk_idx),
        .block_base(blk_base),
        .block_last(blk_last)
    );

    serial_rate_meter u_rate (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .enable(mode_taken_ff && mode_ff == `MODE_BOOT),
        .rx_in(serial_rx),
        .bit_cycles_ff(rate),
        .locked_ff(rate_locked)
    );

    // lowest set block select bit picks the block
    always @* begin
        blk_idx = 3'h7;
        for (i = 7; i >= 0; i = i - 1) begin
            if (block_sel_ff[i]) begin
                blk_idx = i[2:0];
            end
        end
    end

    assign bit_rate_cycles = rate;
    assign op_mode = mode_ff;
    assign busy = (state_ff != ST_IDLE);
    // program/erase gate: mode, pin, software enable and protect
    assign may_alter = mode_taken_ff && (mode_ff != `MODE_USER)
        && hw_write_protect_input
        && ctrl_ff[`CTRL_SWE] && !ctrl_ff[`CTRL_PROTECT];
    assign page_base = {addr_ff[15:7], 7'h00};
    assign cmd = wdata_ff[1:0];

    // ------------------------------------------------------------
    // mode latch: sample pins on first enabled edge after reset
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff <= `MODE_USER;
            mode_taken_ff <= 1'b0;
        end else if (clk_en && !mode_taken_ff) begin
            mode_taken_ff <= 1'b1;
            // pins 1:0 choose the mode; pin 2 reserved
            mode_ff <= {mode_select_pin_1, mode_select_pin_0};
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel capture
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready = !w_ff && !bvalid_ff;
    assign wr_go = aw_ff && w_ff && !bvalid_ff;
    assign wr_ok = (awaddr_ff == `REG_CTRL) || (awaddr_ff == `REG_BLOCK)
        || (awaddr_ff == `REG_ADDR) || (awaddr_ff == `REG_DATA)
        || (awaddr_ff == `REG_CMD);
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
            end
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? 2'h0 : 2'h2;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control registers, page buffer and sequencer
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= `CTRL_RESET;
            block_sel_ff <= 8'h00;
            addr_ff <= 16'h0000;
            state_ff <= ST_IDLE;
            ptr_ff <= 16'h0000;
            last_ff <= 16'h0000;
            pg_idx_ff <= 7'h00;
            refused_ff <= 1'b0;
            bad_page_ff <= 1'b0;
        end else if (clk_en) begin
            if (wr_go && awaddr_ff == `REG_CTRL) begin
                ctrl_ff[`CTRL_SWE] <= wdata_ff[`CTRL_SWE];
                // protect only written while write enable is set or being set
                if (wdata_ff[`CTRL_SWE] || ctrl_ff[`CTRL_SWE])
                    ctrl_ff[`CTRL_PROTECT] <= wdata_ff[`CTRL_PROTECT];
            end
            if (wr_go && awaddr_ff == `REG_BLOCK && !busy) begin
                if (ctrl_ff[`CTRL_SWE])
                    block_sel_ff <= wdata_ff[7:0];
                else
                    block_sel_ff <= block_sel_ff & wdata_ff[7:0];
            end
            if (!ctrl_ff[`CTRL_SWE])
                block_sel_ff <= 8'h00;
            if (wr_go && awaddr_ff == `REG_ADDR && !busy) begin
                addr_ff <= wdata_ff[15:0];
                pg_idx_ff <= wdata_ff[6:0];
            end
            // data writes fill the page buffer byte by byte
            if (wr_go && awaddr_ff == `REG_DATA && !busy) begin
                pg_idx_ff <= pg_idx_ff + 7'h01;
            end
            case (state_ff)
                ST_IDLE: begin
                    if (wr_go && awaddr_ff == `REG_CMD) begin
                        refused_ff <= 1'b0;
                        bad_page_ff <= 1'b0;
                        if (!may_alter) begin
                            refused_ff <= 1'b1;
                        end else if (cmd == `CMD_PROGRAM) begin
                            state_ff <= ST_PROG;
                            ptr_ff <= page_base;
                            bad_page_ff <= (addr_ff[6:0] != 7'h00);
                        end else if (cmd == `CMD_ERASE) begin
                            if (mode_ff == `MODE_BOOT || block_sel_ff == 8'h00) begin
                                refused_ff <= 1'b1;
                            end else begin
                                state_ff <= ST_ERASE;
                                ptr_ff <= blk_base;
                                last_ff <= blk_last;
                            end
                        end else if (cmd == `CMD_ERASE_ALL) begin
                            if (mode_ff == `MODE_BOOT) begin
                                state_ff <= ST_ERASE;
                                ptr_ff <= 16'h0000;
                                last_ff <= 16'hFFFF;
                            end else begin
                                refused_ff <= 1'b1;
                            end
                        end
                    end
                end
                ST_PROG: begin
                    ptr_ff <= ptr_ff + 16'h0001;
                    if (ptr_ff[6:0] == 7'h7F)
                        state_ff <= ST_IDLE;
                end
                ST_ERASE: begin
                    ptr_ff <= ptr_ff + 16'h0001;
                    if (ptr_ff == last_ff)
                        state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // array storage: no reset, buffer loaded from data register
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (clk_en) begin
            if (wr_go && awaddr_ff == `REG_DATA && !busy)
                page_buf[pg_idx_ff] <= wdata_ff[7:0];
            if (state_ff == ST_PROG)
                mem[ptr_ff] <= mem[ptr_ff] & page_buf[ptr_ff[6:0]];
            else if (state_ff == ST_ERASE)
                mem[ptr_ff] <= `ERASED_BYTE;
            rbyte_ff <= mem[addr_ff];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    always @* begin
        rd_ok = 1'b1;
        case ({s_axi_araddr[7:2], 2'h0})
            `REG_CTRL: rd_mux = {30'h0, ctrl_ff};
            `REG_BLOCK: rd_mux = {24'h0, block_sel_ff};
            `REG_ADDR: rd_mux = {16'h0, addr_ff};
            `REG_STATUS: rd_mux = {24'h0, rate_locked, bad_page_ff, refused_ff, busy,
                mode_ff, hw_write_protect_input, mode_taken_ff};
            `REG_RDATA: rd_mux = {24'h0, rbyte_ff};
            `REG_BAUD: rd_mux = {16'h0, rate};
            default: begin
                rd_mux = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= 2'h0;
        end else if (clk_en) begin
            if (s_axi_arvalid && !rvalid_ff) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux;
                rresp_ff <= rd_ok ? 2'h0 : 2'h2;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end
endmodule // flash_mode_ctl

//--- verification/flash_mode_ctl_sva.sv
// port checker for the flash mode controller
// assumes bind onto flash_mode_ctl, single clock aclk
`timescale 1ns/10ps
module flash_mode_ctl_chk (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    input wire mode_select_pin_1,
    input wire mode_select_pin_0,
    input wire [15:0] bit_rate_cycles,
    input wire [1:0] op_mode,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // mode taken from the pins on the first edge out of reset
    property p_mode_latch;
        !$past(aresetn) && clk_en |=>
            op_mode == {$past(mode_select_pin_1), $past(mode_select_pin_0)};
    endproperty
    a_mode_latch: assert property (p_mode_latch) else $error("mode not from pins");
    // mode never moves once latched
    property p_mode_hold;
        $past(aresetn, 2) && $past(clk_en, 2) && $past(aresetn) |-> $stable(op_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
    // rate only measured in boot mode
    property p_rate_boot;
        op_mode != 2'h2 |-> bit_rate_cycles == 16'h0000;
    endproperty
    a_rate_boot: assert property (p_rate_boot) else $error("rate outside boot");
    // write answered two edges after both halves taken together
    property p_wr_resp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en
            |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
    // write answer drops after its handshake
    property p_b_done;
        s_axi_bvalid && s_axi_bready && clk_en |=> !s_axi_bvalid;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write answer repeated");
    // read answered one edge after address taken
    property p_r_ans;
        s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid;
    endproperty
    a_r_ans: assert property (p_r_ans) else $error("read not answered");
    // read answer drops after its handshake
    property p_r_done;
        s_axi_rvalid && s_axi_rready && clk_en |=> !s_axi_rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read answer repeated");
    // error reads carry zero data
    property p_slverr_zero;
        s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h00000000;
    endproperty
    a_slverr_zero: assert property (p_slverr_zero) else $error("error read with data");
    // main scenarios reached
    c_boot_rate: cover property (op_mode == 2'h2 && bit_rate_cycles != 16'h0000);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    c_programmer: cover property (op_mode == 2'h3);
endmodule // flash_mode_ctl_chk

bind flash_mode_ctl flash_mode_ctl_chk flash_mode_ctl_chk_i (.aclk(aclk), .aresetn(aresetn),
    .clk_en(clk_en), .mode_select_pin_1(mode_select_pin_1),
    .mode_select_pin_0(mode_select_pin_0), .bit_rate_cycles(bit_rate_cycles),
    .op_mode(op_mode), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

//--- verification/host_serial_model.sv
// host serial line: one start bit of set length
// assumes aclk shared with the controller; line idles high
`timescale 1ns/10ps
module host_serial_model (
    input wire aclk,
    input wire send,
    input wire [15:0] low_cycles,
    output reg serial_rx
);
    reg [15:0] cnt_ff;
    initial begin
        serial_rx = 1'h1;
        cnt_ff = 16'h0000;
    end
    // start bit held low for low_cycles clocks
    always @(posedge aclk) begin
        if (send) begin
            serial_rx <= 1'h0;
            cnt_ff <= low_cycles;
        end else if (cnt_ff > 16'h0001) begin
            cnt_ff <= cnt_ff - 16'h0001;
        end else begin
            serial_rx <= 1'h1;
            cnt_ff <= 16'h0000;
        end
    end
endmodule // host_serial_model

//--- verification/tb.sv
// self-checking bench for the flash mode controller
// assumes controller top, its defines and the host serial model
`timescale 1ns/10ps
`include "flash_ctl_defines.vh"
module tb;
    reg aclk = 1'h0;
    reg aresetn = 1'h0;
    reg clk_en = 1'h1;
    reg wp = 1'h1;
    reg [2:0] pins = 3'h0;
    reg [7:0] awaddr = 8'h00;
    reg awvalid = 1'h0;
    reg [31:0] wdata = 32'h00000000;
    reg wvalid = 1'h0;
    reg bready = 1'h0;
    reg [7:0] araddr = 8'h00;
    reg arvalid = 1'h0;
    reg rready = 1'h0;
    reg send = 1'h0;
    wire awready, wready, bvalid, arready, rvalid, serial_rx;
    wire [1:0] bresp, rresp, op_mode;
    wire [31:0] rdata;
    wire [15:0] rate;
    integer fails = 0;
    integer checks_done = 0;
    integer cycles = 0;
    integer i;
    reg [31:0] d;
    reg [1:0] rr;
    reg [15:0] tc [0:7];
    flash_mode_ctl flash_mode_ctl_i (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .hw_write_protect_input(wp), .mode_select_pin_2(pins[2]),
        .mode_select_pin_1(pins[1]), .mode_select_pin_0(pins[0]), .serial_rx(serial_rx),
        .bit_rate_cycles(rate), .op_mode(op_mode), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    host_serial_model host_serial_model_i (.aclk(aclk), .send(send),
        .low_cycles(16'h0028), .serial_rx(serial_rx));
    // 100 ns clock
    initial begin
        forever #50 aclk = ~aclk;
    end
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("wrong value at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] v, input [1:0] er);
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= v;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            do begin
                @(posedge aclk);
                if (awready && clk_en) awvalid <= 1'h0;
                if (wready && clk_en) wvalid <= 1'h0;
            end while (!((awready || !awvalid) && (wready || !wvalid) && clk_en));
            do @(posedge aclk); while (!(bvalid && clk_en));
            chk({30'h0, bresp}, {30'h0, er});
            bready <= 1'h0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            do @(posedge aclk); while (!(arready && clk_en));
            arvalid <= 1'h0;
            do @(posedge aclk); while (!(rvalid && clk_en));
            d = rdata;
            rr = rresp;
            rready <= 1'h0;
        end
    endtask
    task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
        begin
            rd(a);
            chk(d & m, e);
        end
    endtask
    task rb(input [15:0] a, input [7:0] e);
        begin
            wr(`REG_ADDR, {16'h0, a}, 2'h0);
            rdc(`REG_RDATA, 32'h000000FF, {24'h0, e});
        end
    endtask
    task cmd(input [1:0] c);
        begin
            wr(`REG_CMD, {30'h0, c}, 2'h0);
            do rd(`REG_STATUS); while (d[4] !== 1'h0);
        end
    endtask
    task do_reset(input [1:0] m, input p);
        begin
            @(posedge aclk);
            aresetn <= 1'h0;
            pins <= {~m[0], m};
            wp <= p;
            repeat (5) @(posedge aclk);
            aresetn <= 1'h1;
            repeat (2) @(posedge aclk);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask
    // hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            fails = fails + 1;
            $display("wrong value at %0t: timeout", $time);
            end_sim;
        end
    end
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        tc[0] = 16'h280D;
        tc[1] = 16'hA80D;
        tc[2] = 16'h480D;
        tc[3] = 16'h780D;
        tc[4] = 16'h680F;
        tc[5] = 16'hE80C;
        tc[6] = 16'h600D;
        tc[7] = 16'hA806;
        do_reset(2'h1, 1'h1);
        rdc(`REG_STATUS, 32'h0000000F, 32'h00000007);
        rd(8'h20);
        chk({30'h0, rr}, 32'h00000002);
        chk(d, 32'h00000000);
        wr(8'h20, 32'h00000000, 2'h2);
        wr(`REG_CTRL, 32'h00000001, 2'h0);
        wr(`REG_BLOCK, 32'h00000002, 2'h0);
        cmd(`CMD_ERASE);
        wr(`REG_ADDR, 32'h00000400, 2'h0);
        for (i = 0; i < 128; i = i + 1) wr(`REG_DATA, i ^ 32'h5A, 2'h0);
        cmd(`CMD_PROGRAM);
        rdc(`REG_STATUS, 32'h00000040, 32'h00000000);
        rb(16'h0400, 8'h5A);
        rb(16'h047F, 8'h25);
        rb(16'h0480, 8'hFF);
        wr(`REG_BLOCK, 32'h00000001, 2'h0);
        cmd(`CMD_ERASE);
        rb(16'h03FF, 8'hFF);
        rb(16'h0400, 8'h5A);
        // write enable clear: block and protect bits cannot be set
        wr(`REG_CTRL, 32'h00000000, 2'h0);
        wr(`REG_BLOCK, 32'h000000FF, 2'h0);
        rdc(`REG_BLOCK, 32'h000000FF, 32'h00000000);
        wr(`REG_CTRL, 32'h00000002, 2'h0);
        rdc(`REG_CTRL, 32'h00000003, 32'h00000000);
        // mode, pin, control, block and command table
        for (i = 0; i < 8; i = i + 1) begin
            do_reset(tc[i][15:14], tc[i][13]);
            wr(`REG_CTRL, {30'h0, tc[i][12:11]}, 2'h0);
            wr(`REG_BLOCK, {24'h0, tc[i][10:3]}, 2'h0);
            cmd(tc[i][2:1]);
            rdc(`REG_STATUS, 32'h20, {26'h0, tc[i][0], 5'h0});
        end
        rb(16'hFFFF, 8'hFF);
        send <= 1'h1;
        @(posedge aclk);
        send <= 1'h0;
        do rd(`REG_STATUS); while (d[7] !== 1'h1);
        rd(`REG_BAUD);
        chk({31'h0, d > 32'h00000026 && d < 32'h0000002A}, 32'h00000001);
        chk({16'h0, rate}, 32'h00000028);
        end_sim;
    end
endmodule // tb
